// ==== src/bt_lfsr.sv ====
// Programmable two-tap shift register used as pattern generator and as reference
`timescale 1ns/1ps
`default_nettype none
module bt_lfsr (
  // Clock and control
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  // Engine port
  bt_lfsr_if.core p
);
  logic [31:0] state;
  wire tap_a_bit = state[p.len_m1];
  wire tap_b_bit = state[p.tap_b];
  wire fb_bit = p.rep_mode ? tap_a_bit : (tap_a_bit ^ tap_b_bit);
  wire in_bit = p.ext_en ? p.ext_bit : fb_bit;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state <= 32'h0000_0000;
    end else if (ce_i) begin
      if (p.load) begin
        state <= p.seed;
      end else if (p.step) begin
        state <= {state[30:0], in_bit};
      end
    end
  end

  assign p.state = state;
  assign p.fb = fb_bit;
  assign p.out_bit = tap_a_bit;
endmodule : bt_lfsr
`default_nettype wire

// ==== src/bt_lfsr_if.sv ====
// Control and state signals between the tester and one shift register engine
`timescale 1ns/1ps
`default_nettype none
interface bt_lfsr_if;
  logic load;
  logic [31:0] seed;
  logic step;
  logic ext_en;
  logic ext_bit;
  logic rep_mode;
  logic [4:0] len_m1;
  logic [4:0] tap_b;
  logic [31:0] state;
  logic fb;
  logic out_bit;
  modport ctl (output load, seed, step, ext_en, ext_bit, rep_mode, len_m1, tap_b,
               input state, fb, out_bit);
  modport core (input load, seed, step, ext_en, ext_bit, rep_mode, len_m1, tap_b,
                output state, fb, out_bit);
endinterface : bt_lfsr_if
`default_nettype wire

// ==== src/bt_pkg.sv ====
// Register map, field positions, reset values and timing constants of the tester
package bt_pkg;
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_LEN = 8'h04;
  localparam logic [7:0] A_TAP = 8'h08;
  localparam logic [7:0] A_PAT = 8'h0c;
  localparam logic [7:0] A_EINS = 8'h10;
  localparam logic [7:0] A_STAT = 8'h14;
  localparam logic [7:0] A_ERRC = 8'h18;
  localparam logic [7:0] A_BITC = 8'h1c;
  localparam logic [7:0] A_RXPAT = 8'h20;
  localparam logic [7:0] A_IEN = 8'h24;
  localparam int C_REP = 0, C_SYNC_EN = 1, C_RESYNC = 2, C_LOAD_CNT = 4, C_TX_LOAD = 7;
  localparam int E_SINGLE = 3;
  localparam int S_SYNC = 0, S_ALL1 = 1, S_ALL0 = 2, S_LOSS = 3;
  localparam int P_TL = 0, P_LC = 1, P_TEST = 2, P_TXCK = 3, P_RXCK = 4, P_RXD = 5;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [4:0] LEN_RST = 5'h1f;
  localparam logic [4:0] TAP_RST = 5'h00;
  localparam logic [31:0] PAT_RST = 32'h0000_0000;
  localparam logic [3:0] EINS_RST = 4'h0;
  localparam logic [3:0] IEN_RST = 4'h0;
  localparam int TX_MSB_EDGE = 3;
  localparam logic [1:0] TX_WAIT_INIT = 2'(TX_MSB_EDGE - 1);
  localparam logic [6:0] SYNC_BASE = 7'h22;
  localparam logic [4:0] LOSS_WIN_LAST = 5'h1f;
  localparam logic [2:0] LOSS_ERRS = 3'h6;
  typedef enum logic [1:0] {
    SYNC_OFF = 2'b00,
    SYNC_HUNT = 2'b01,
    SYNC_LOCK = 2'b10
  } bt_sync_t;
endpackage : bt_pkg

// ==== src/bt_tester.sv ====
// Bit error rate tester: AHB-Lite registers, pattern transmitter and receive checker
//
// Local design decisions: the AHB-Lite register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// [R1] A rising transmit load copies the pattern set register into the generator.
// [R2] Pattern MSB leaves on the third transmit clock rising edge after load.
// [R3] Transmit load pin and control bit 7 are ORed as load source.
// [R4] Test input high releases interrupt, bus data, serial data and sync-loss drivers; here the AHB read data is never released.
// [R5] Pseudorandom sync needs 34 plus n consecutive error-free received bits.
// [R6] While synchronized, status bit 0 is set and mismatching bits are counted.
// [R7] Pseudorandom check tests the polynomial; ones and zeros streams also pass; here only zeros pass, an all-ones stream never syncs.
// [R8] Repetitive check accepts any repeating pattern of the programmed length.
// [R9] Control register holds sync enable and resync bits for the synchronizer.
// [R10] Host qualifies sync with all-ones/zeros flags and the received pattern.
// [R11] Host sets integration period by spacing load count assertions.
// [R12] Host divides latched error count by latched bit count.
// [R13] Single error or one-in-ten to one-in-ten-million error rate insertion.
// [R14] First feedback tap always equals programmed length minus one.
// [R15] Second feedback tap is programmable to any bit position.
// [R16] Polynomials up to degree 32, repetitive patterns of 1 to 32 bits.
// [R17] Bit counter and error counter are 32 bits wide.
// [R18] Transmit and receive sections work independently.
// [R19] Host writes every register to a known value before relying on it.
// [R20] Rising load count, ORed with control bit 4, latches and clears counts.
// [R21] Active-high sync-loss output shows synchronizer state in real time.
// [R22] Active-low open-drain interrupt flags enabled status conditions.
// [R23] Host port captures the address first, data follows, select required.
// [R24] One bit sent per transmit clock edge, one taken per receive clock edge.
// [R25] An inserted error inverts the bit that would have been sent.
module bt_tester (
  // Clock, reset, enable
  input wire logic core_clk_i,
  input wire logic rstn_i,
  input wire logic ce_i,
  // AHB-Lite slave
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  // Control pins
  input wire logic transmit_load_i,
  input wire logic load_count_i,
  input wire logic test_i,
  // Transmit link
  input wire logic tx_bit_clock_i,
  output logic tx_data_o,
  output logic tx_data_oe_o,
  // Receive link
  input wire logic rx_bit_clock_i,
  input wire logic rx_data_i,
  output logic rx_sync_loss_o,
  output logic rx_sync_loss_oe_o,
  // Open-drain interrupt
  output logic int_n_o,
  output logic int_n_oe_o
);
  function automatic logic [31:0] len_mask(input logic [4:0] len_m1);
    len_mask = 32'hffff_ffff >> (5'h1f - len_m1);
  endfunction : len_mask

  function automatic logic [23:0] period_m1(input logic [2:0] k);
    case (k)
      3'h1: period_m1 = 24'd9;
      3'h2: period_m1 = 24'd99;
      3'h3: period_m1 = 24'd999;
      3'h4: period_m1 = 24'd9999;
      3'h5: period_m1 = 24'd99999;
      3'h6: period_m1 = 24'd999999;
      3'h7: period_m1 = 24'd9999999;
      default: period_m1 = 24'h00_0000;
    endcase
  endfunction : period_m1

  // Reset release
  logic [1:0] rst_ff;
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) rst_ff <= 2'b00;
    else rst_ff <= {rst_ff[0], 1'b1};
  end
  wire rst_n = rst_ff[1];

  // Pin synchronisers, third stage for edge detection
  wire [5:0] pins_in = {rx_data_i, rx_bit_clock_i, tx_bit_clock_i, test_i, load_count_i,
                        transmit_load_i};
  logic [5:0] pin_m;
  logic [5:0] pin_s;
  logic [5:0] pin_q;
  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      pin_m <= 6'h00;
      pin_s <= 6'h00;
      pin_q <= 6'h00;
    end else if (ce_i) begin
      pin_m <= pins_in;
      pin_s <= pin_m;
      pin_q <= pin_s;
    end
  end

  // Software registers
  logic [7:0] ctrl;
  logic [4:0] len_m1;
  logic [4:0] tap_b;
  logic [31:0] pat_set;
  logic [3:0] eins;
  logic [3:0] ien;
  logic [31:0] errc_latch;
  logic [31:0] bitc_latch;
  logic [31:0] rdata;

  // AHB-Lite slave, no wait states while enabled
  logic wr_pend;
  logic [7:0] wr_addr;
  wire ahb_go = ce_i & hsel_i & htrans_i[1] & hready_i;
  wire wr_en = ce_i & wr_pend;
  wire wr_ctrl = wr_en & (wr_addr == bt_pkg::A_CTRL);
  wire wr_len = wr_en & (wr_addr == bt_pkg::A_LEN);
  wire wr_tap = wr_en & (wr_addr == bt_pkg::A_TAP);
  wire wr_pat = wr_en & (wr_addr == bt_pkg::A_PAT);
  wire wr_eins = wr_en & (wr_addr == bt_pkg::A_EINS);
  wire wr_ien = wr_en & (wr_addr == bt_pkg::A_IEN);
  wire resync_p = wr_ctrl & hwdata_i[bt_pkg::C_RESYNC];
  wire single_set = wr_eins & hwdata_i[bt_pkg::E_SINGLE];
  logic [31:0] rd_mux;
  logic [3:0] status;
  logic [31:0] rx_pat;

  always_comb begin
    case (haddr_i[7:0])
      bt_pkg::A_CTRL: rd_mux = {24'h00_0000, ctrl};
      bt_pkg::A_LEN: rd_mux = {27'h000_0000, len_m1};
      bt_pkg::A_TAP: rd_mux = {27'h000_0000, tap_b};
      bt_pkg::A_PAT: rd_mux = pat_set;
      bt_pkg::A_EINS: rd_mux = {28'h000_0000, eins};
      bt_pkg::A_STAT: rd_mux = {28'h000_0000, status};
      bt_pkg::A_ERRC: rd_mux = errc_latch;
      bt_pkg::A_BITC: rd_mux = bitc_latch;
      bt_pkg::A_RXPAT: rd_mux = rx_pat;
      bt_pkg::A_IEN: rd_mux = {28'h000_0000, ien};
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
      rdata <= 32'h0000_0000;
    end else if (ce_i) begin
      wr_pend <= ahb_go & hwrite_i; // R23
      if (ahb_go) wr_addr <= haddr_i[7:0]; // R23
      if (ahb_go && !hwrite_i) rdata <= rd_mux;
    end
  end

  logic single_pend;
  logic tx_inject;
  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      ctrl <= bt_pkg::CTRL_RST;
      len_m1 <= bt_pkg::LEN_RST;
      tap_b <= bt_pkg::TAP_RST;
      pat_set <= bt_pkg::PAT_RST;
      eins <= bt_pkg::EINS_RST;
      ien <= bt_pkg::IEN_RST;
    end else if (ce_i) begin
      if (wr_ctrl) ctrl <= hwdata_i[7:0] & ~(8'h01 << bt_pkg::C_RESYNC); // R9
      if (wr_len) len_m1 <= hwdata_i[4:0]; // R16
      if (wr_tap) tap_b <= hwdata_i[4:0]; // R15
      if (wr_pat) pat_set <= hwdata_i;
      if (wr_eins) eins <= {1'b0, hwdata_i[2:0]};
      if (wr_ien) ien <= hwdata_i[3:0];
    end
  end

  assign hrdata_o = rdata;
  assign hreadyout_o = ce_i;
  assign hresp_o = 1'b0;

  // Load sources and link clock edges
  wire tl_src = pin_s[bt_pkg::P_TL] | ctrl[bt_pkg::C_TX_LOAD]; // R3
  wire lc_src = pin_s[bt_pkg::P_LC] | ctrl[bt_pkg::C_LOAD_CNT]; // R20
  logic tl_q;
  logic lc_q;
  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      tl_q <= 1'b0;
      lc_q <= 1'b0;
    end else if (ce_i) begin
      tl_q <= tl_src;
      lc_q <= lc_src;
    end
  end
  wire load_evt = ce_i & tl_src & ~tl_q; // R1
  wire lc_evt = ce_i & lc_src & ~lc_q; // R20
  wire tx_edge = ce_i & pin_s[bt_pkg::P_TXCK] & ~pin_q[bt_pkg::P_TXCK]; // R24
  wire rx_edge = ce_i & pin_s[bt_pkg::P_RXCK] & ~pin_q[bt_pkg::P_RXCK]; // R24
  wire test_on = pin_s[bt_pkg::P_TEST];

  // Transmit section, its own engine
  bt_lfsr_if t_if ();
  bt_lfsr u_tx_gen (.clk_i(core_clk_i), .rst_n_i(rst_n), .ce_i(ce_i), .p(t_if.core));
  logic [1:0] tx_wait;
  logic [23:0] ei_cnt;
  logic tx_bit;
  wire tx_step = tx_edge & (tx_wait == 2'h0) & ~load_evt;
  wire [2:0] ei_rate = eins[2:0];
  wire rate_hit = (ei_rate != 3'h0) & (ei_cnt == period_m1(ei_rate)); // R13
  assign tx_inject = single_pend | rate_hit; // R13
  assign t_if.load = load_evt; // R1
  assign t_if.seed = pat_set & len_mask(len_m1);
  assign t_if.step = tx_step; // R24
  assign t_if.ext_en = 1'b0;
  assign t_if.ext_bit = 1'b0;
  assign t_if.rep_mode = ctrl[bt_pkg::C_REP];
  assign t_if.len_m1 = len_m1; // R14
  assign t_if.tap_b = tap_b; // R15

  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      tx_wait <= 2'h0;
      ei_cnt <= 24'h00_0000;
      tx_bit <= 1'b0;
      single_pend <= 1'b0;
    end else if (ce_i) begin
      if (load_evt) tx_wait <= bt_pkg::TX_WAIT_INIT; // R2
      else if (tx_edge && tx_wait != 2'h0) tx_wait <= tx_wait - 2'h1; // R2
      if (tx_step) tx_bit <= t_if.out_bit ^ tx_inject; // R25
      if (tx_step) ei_cnt <= rate_hit || ei_rate == 3'h0 ? 24'h00_0000 : ei_cnt + 24'h1;
      single_pend <= (single_pend & ~tx_step) | single_set;
    end
  end

  // Receive section, reference engine follows data until lock
  bt_lfsr_if r_if ();
  bt_lfsr u_rx_ref (.clk_i(core_clk_i), .rst_n_i(rst_n), .ce_i(ce_i), .p(r_if.core)); // R18
  bt_pkg::bt_sync_t sync_st;
  bt_pkg::bt_sync_t next_sync_st;
  logic [6:0] match_cnt;
  logic [4:0] win_cnt;
  logic [2:0] win_err;
  logic [31:0] bit_cnt;
  logic [31:0] err_cnt;
  logic loss_q;
  wire rx_bit = pin_s[bt_pkg::P_RXD];
  wire locked = (sync_st == bt_pkg::SYNC_LOCK);
  wire mismatch = rx_bit ^ r_if.fb; // R7 R8
  wire [6:0] sync_need = bt_pkg::SYNC_BASE + {2'b00, len_m1} + 7'h1; // R5
  wire [31:0] rx_mask = len_mask(len_m1);
  assign r_if.load = 1'b0;
  assign r_if.seed = 32'h0000_0000;
  assign r_if.step = rx_edge; // R24
  assign r_if.ext_en = ~locked;
  assign r_if.ext_bit = rx_bit;
  assign r_if.rep_mode = ctrl[bt_pkg::C_REP];
  assign r_if.len_m1 = len_m1;
  assign r_if.tap_b = tap_b;
  assign rx_pat = r_if.state & rx_mask;
  wire all1 = (rx_pat == rx_mask);
  wire all0 = (rx_pat == 32'h0000_0000);
  wire win_lost = locked & rx_edge & mismatch & (win_err == bt_pkg::LOSS_ERRS - 3'h1);

  always_comb begin
    next_sync_st = sync_st;
    case (sync_st)
      bt_pkg::SYNC_OFF: next_sync_st = bt_pkg::SYNC_HUNT;
      bt_pkg::SYNC_HUNT: begin
        if (rx_edge && !mismatch && match_cnt == sync_need - 7'h1) begin
          next_sync_st = bt_pkg::SYNC_LOCK; // R5
        end
      end
      bt_pkg::SYNC_LOCK: begin
        if (win_lost) next_sync_st = bt_pkg::SYNC_HUNT;
      end
      default: next_sync_st = bt_pkg::SYNC_OFF;
    endcase
    if (resync_p) next_sync_st = bt_pkg::SYNC_HUNT; // R9
    if (!ctrl[bt_pkg::C_SYNC_EN]) next_sync_st = bt_pkg::SYNC_OFF; // R9
  end

  wire cnt_bit = rx_edge & locked; // R6
  wire cnt_err = cnt_bit & mismatch; // R6
  wire [31:0] bit_base = lc_evt ? 32'h0000_0000 : bit_cnt; // R20
  wire [31:0] err_base = lc_evt ? 32'h0000_0000 : err_cnt; // R20

  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      sync_st <= bt_pkg::SYNC_OFF;
      match_cnt <= 7'h00;
      win_cnt <= 5'h00;
      win_err <= 3'h0;
    end else if (ce_i) begin
      sync_st <= next_sync_st;
      if (sync_st != bt_pkg::SYNC_HUNT || resync_p) match_cnt <= 7'h00;
      else if (rx_edge) match_cnt <= mismatch ? 7'h00 : match_cnt + 7'h1; // R5
      if (!locked || win_lost) begin
        win_cnt <= 5'h00;
        win_err <= 3'h0;
      end else if (rx_edge) begin
        win_cnt <= win_cnt + 5'h1;
        if (win_cnt == bt_pkg::LOSS_WIN_LAST) win_err <= {2'b00, mismatch};
        else win_err <= win_err + {2'b00, mismatch};
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      bit_cnt <= 32'h0000_0000;
      err_cnt <= 32'h0000_0000;
      bitc_latch <= 32'h0000_0000;
      errc_latch <= 32'h0000_0000;
      loss_q <= 1'b1;
    end else if (ce_i) begin
      bit_cnt <= bit_base + {31'h0, cnt_bit}; // R17
      err_cnt <= err_base + {31'h0, cnt_err}; // R17
      if (lc_evt) bitc_latch <= bit_cnt; // R20
      if (lc_evt) errc_latch <= err_cnt; // R20
      loss_q <= (next_sync_st != bt_pkg::SYNC_LOCK); // R21
    end
  end

  // Status and pin drivers
  assign status = {loss_q, all0, all1, locked}; // R6
  wire int_act = |(status & ien); // R22
  assign tx_data_o = tx_bit;
  assign tx_data_oe_o = ~test_on; // R4
  assign rx_sync_loss_o = loss_q; // R21
  assign rx_sync_loss_oe_o = ~test_on; // R4
  assign int_n_o = 1'b0; // R22
  assign int_n_oe_o = int_act & ~test_on; // R4 R22

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_n);

  chk_load_copy: assert property (load_evt |=> t_if.state == $past(t_if.seed)) // R1
    else $error("generator not loaded from pattern set");
  chk_load_wait: assert property (load_evt |=> tx_wait == 2'h2 ##0 !tx_step) // R2
    else $error("load did not start three-edge wait");
  chk_tx_bit: assert property (tx_step |=>
                               tx_data_o == ($past(t_if.out_bit) ^ $past(tx_inject))) // R25
    else $error("transmitted bit not generator bit with inversion");
  chk_load_or: assert property (ce_i && !tl_q && ctrl[7] |-> load_evt) // R3
    else $error("control load bit did not trigger load");
  chk_test_hiz: assert property (test_on |-> !tx_data_oe_o && !rx_sync_loss_oe_o
                                 && !int_n_oe_o) // R4
    else $error("driver enabled during test");
  chk_sync_run: assert property ($rose(locked) |-> $past(match_cnt) == sync_need - 7'h1) // R5
    else $error("sync declared without full error-free run");
  chk_err_count: assert property (cnt_err && !lc_evt |=> err_cnt == $past(err_cnt) + 32'h1) // R6
    else $error("error not counted while synchronized");
  chk_cnt_latch: assert property (lc_evt |=> bitc_latch == $past(bit_cnt)
                                  && bit_cnt == {31'h0, $past(cnt_bit)}) // R20
    else $error("load count did not latch and clear");
  chk_loss_pin: assert property (ce_i |=> rx_sync_loss_o == !locked) // R21
    else $error("sync loss output disagrees with synchronizer");
  chk_unlock_hold: assert property (!ctrl[1] && ce_i |=> sync_st == bt_pkg::SYNC_OFF) // R9
    else $error("synchronizer ran while disabled");

  cov_lock: cover property ($rose(locked));
  cov_tx_load: cover property (load_evt ##[1:200] tx_step);
  cov_inject: cover property (tx_step && tx_inject);
  cov_latch: cover property (lc_evt && bit_cnt != 32'h0);
endmodule : bt_tester
`default_nettype wire

// ==== tb/bt_link_model.sv ====
// Loopback link model: makes the bit clocks and returns each sent bit one bit later
`timescale 1ns/1ps
`default_nettype none
module bt_link_model (
  // Bench control
  input wire logic run_i,
  input wire logic flip_i,
  input wire logic zero_i,
  // Tester side
  input wire logic tx_data_i,
  input wire logic tx_oe_i,
  output logic tx_clk_o,
  output logic rx_clk_o,
  output logic rx_data_o
);
  logic last;
  logic line;
  // A released line shows the inverse of its last level
  assign line = tx_oe_i ? tx_data_i : ~last;
  // Receive clock rises mid-bit so its data is steady around the edge
  assign rx_clk_o = ~tx_clk_o;
  initial begin
    tx_clk_o = 1'b0;
    #10;
    forever begin
      #200;
      if (run_i) begin
        tx_clk_o = ~tx_clk_o;
      end
    end
  end
  always @(posedge tx_clk_o) begin
    last <= line;
    rx_data_o <= zero_i ? 1'b0 : line ^ flip_i;
  end
endmodule : bt_link_model
`default_nettype wire

// ==== tb/tb_top.sv ====
// Self-checking bench of the bit error rate tester with a loopback link
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  localparam logic [31:0] K_REP = 32'h1 << bt_pkg::C_REP;
  localparam logic [31:0] K_SE = 32'h1 << bt_pkg::C_SYNC_EN;
  localparam logic [31:0] K_RS = 32'h1 << bt_pkg::C_RESYNC;
  localparam logic [31:0] K_LC = 32'h1 << bt_pkg::C_LOAD_CNT;
  localparam logic [31:0] K_TL = 32'h1 << bt_pkg::C_TX_LOAD;
  logic core_clk_i;
  logic rstn_i;
  logic hsel;
  logic [31:0] haddr;
  logic [1:0] htrans;
  logic hwrite;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic tl, lc, test, flip, zero;
  logic tx_clk, rx_clk, rx_data, tx_data, tx_oe, loss, loss_oe, int_n, int_oe;
  logic [31:0] q;
  int n_errors;
  int compares;
  int n_rx = 0;
  bt_tester uut (.core_clk_i(core_clk_i), .rstn_i(rstn_i), .ce_i(1'b1), .hsel_i(hsel),
    .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2),
    .hwdata_i(hwdata), .hready_i(hreadyout), .hrdata_o(hrdata), .hreadyout_o(hreadyout),
    .hresp_o(hresp), .transmit_load_i(tl), .load_count_i(lc), .test_i(test),
    .tx_bit_clock_i(tx_clk), .tx_data_o(tx_data), .tx_data_oe_o(tx_oe),
    .rx_bit_clock_i(rx_clk), .rx_data_i(rx_data), .rx_sync_loss_o(loss),
    .rx_sync_loss_oe_o(loss_oe), .int_n_o(int_n), .int_n_oe_o(int_oe));
  bt_link_model link (.run_i(1'b1), .flip_i(flip), .zero_i(zero), .tx_data_i(tx_data),
    .tx_oe_i(tx_oe), .tx_clk_o(tx_clk), .rx_clk_o(rx_clk), .rx_data_o(rx_data));
  initial begin
    core_clk_i = 1'b0;
    forever #25 core_clk_i = ~core_clk_i;
  end
  always @(posedge rx_clk) n_rx <= n_rx + 1;
  task automatic complete_run;
    $display("compares %0d mismatches %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : complete_run
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  task automatic hang(input string nm);
    n_errors++;
    $display("Error %s expected done seen timeout", nm);
    complete_run();
  endtask : hang
  task automatic wait_rdy;
    int i;
    i = 0;
    do begin
      @(posedge core_clk_i);
      i++;
    end while (hreadyout !== 1'b1 && i < 40);
    if (hreadyout !== 1'b1) hang("hready");
  endtask : wait_rdy
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk_i);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'b10;
    hwrite <= w;
    wait_rdy();
    htrans <= 2'b00;
    hwdata <= d;
    wait_rdy();
    q = hrdata;
    check("hresp", {31'h0, hresp}, 32'h0);
  endtask : ahb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    ahb(1'b1, a, d);
  endtask : wr
  task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] exp);
    ahb(1'b0, a, 32'h0);
    check(nm, q, exp);
  endtask : rd_chk
  task automatic wait_lock;
    int i;
    // Let a resync or enable written just now reach the loss output first
    repeat (2) @(posedge core_clk_i);
    for (i = 0; i < 6000 && loss !== 1'b0; i++) @(posedge core_clk_i);
    if (loss !== 1'b0) hang("lock");
  endtask : wait_lock
  task automatic latch(input logic pin);
    if (pin) begin
      @(posedge core_clk_i);
      lc <= 1'b1;
      repeat (4) @(posedge core_clk_i);
      lc <= 1'b0;
      repeat (4) @(posedge core_clk_i);
    end else begin
      wr(bt_pkg::A_CTRL, K_SE | K_LC);
      wr(bt_pkg::A_CTRL, K_SE);
    end
  endtask : latch
  task automatic flip_bit;
    @(negedge tx_clk);
    @(posedge core_clk_i);
    flip <= 1'b1;
    @(negedge tx_clk);
    @(posedge core_clk_i);
    flip <= 1'b0;
  endtask : flip_bit
  task automatic t_regs;
    rd_chk("ctrl rst", bt_pkg::A_CTRL, {24'h0, bt_pkg::CTRL_RST});
    rd_chk("len rst", bt_pkg::A_LEN, {27'h0, bt_pkg::LEN_RST});
    rd_chk("tap rst", bt_pkg::A_TAP, {27'h0, bt_pkg::TAP_RST});
    rd_chk("pat rst", bt_pkg::A_PAT, bt_pkg::PAT_RST);
    rd_chk("eins rst", bt_pkg::A_EINS, {28'h0, bt_pkg::EINS_RST});
    rd_chk("ien rst", bt_pkg::A_IEN, {28'h0, bt_pkg::IEN_RST});
    wr(bt_pkg::A_TAP, 32'hffff_ffff);
    rd_chk("tap rw", bt_pkg::A_TAP, 32'h0000_001f);
    wr(bt_pkg::A_PAT, 32'ha5c3_0f96);
    rd_chk("pat rw", bt_pkg::A_PAT, 32'ha5c3_0f96);
    wr(8'h30, 32'hffff_ffff);
    rd_chk("unmapped", 8'h30, 32'h0);
    $display("test regs done");
  endtask : t_regs
  // Load on a falling transmit clock so the next rising edge is the first one counted
  task automatic tx_pat(input logic [7:0] p, input logic pin);
    int k;
    wr(bt_pkg::A_PAT, {24'h0, p});
    @(negedge tx_clk);
    if (pin) begin
      @(posedge core_clk_i);
      tl <= 1'b1;
    end else begin
      wr(bt_pkg::A_CTRL, K_REP | K_TL);
    end
    repeat (3) @(posedge tx_clk);
    for (k = 0; k < 16; k++) begin
      @(posedge tx_clk);
      check("tx bit", {31'h0, tx_data}, {31'h0, p[7 - (k % 8)]});
    end
    @(posedge core_clk_i);
    tl <= 1'b0;
    wr(bt_pkg::A_CTRL, K_REP);
  endtask : tx_pat
  task automatic t_tx;
    wr(bt_pkg::A_LEN, 32'h7);
    wr(bt_pkg::A_CTRL, K_REP);
    tx_pat(8'hb4, 1'b0);
    tx_pat(8'h5a, 1'b1);
    wr(bt_pkg::A_CTRL, K_REP | K_SE);
    wait_lock();
    rd_chk("rep stat", bt_pkg::A_STAT, 32'h1);
    $display("test tx done");
  endtask : t_tx
  task automatic t_prbs;
    int s;
    int e;
    wr(bt_pkg::A_LEN, 32'h6);
    wr(bt_pkg::A_TAP, 32'h5);
    wr(bt_pkg::A_PAT, 32'h7f);
    wr(bt_pkg::A_CTRL, K_TL);
    repeat (2) @(posedge core_clk_i);
    check("sync off", {31'h0, loss}, 32'h1);
    wr(bt_pkg::A_CTRL, K_SE | K_RS);
    s = n_rx;
    wait_lock();
    // One receive edge may already sit in the pin synchroniser when counting starts
    check("lock bits", {31'h0, (n_rx - s) >= 40}, 32'h1);
    rd_chk("prbs stat", bt_pkg::A_STAT, 32'h1);
    latch(1'b0);
    s = n_rx;
    wait_rx(40);
    flip_bit();
    wait_rx(40);
    flip_bit();
    wr(bt_pkg::A_EINS, 32'h8);
    wait_rx(40);
    latch(1'b1);
    e = n_rx - s;
    rd_chk("err count", bt_pkg::A_ERRC, 32'h3);
    ahb(1'b0, bt_pkg::A_BITC, 32'h0);
    check("bit count", {31'h0, q >= 32'(e - 3) && q <= 32'(e + 3)}, 32'h1);
    wr(bt_pkg::A_EINS, 32'h1);
    latch(1'b0);
    s = n_rx;
    wait_rx(300);
    latch(1'b1);
    e = (n_rx - s) / 10;
    wr(bt_pkg::A_EINS, 32'h0);
    ahb(1'b0, bt_pkg::A_ERRC, 32'h0);
    check("rate", {31'h0, q >= 32'(e - 2) && q <= 32'(e + 2)}, 32'h1);
    @(posedge core_clk_i);
    zero <= 1'b1;
    wr(bt_pkg::A_CTRL, K_SE | K_RS);
    wait_lock();
    rd_chk("zero stat", bt_pkg::A_STAT, 32'h5);
    @(posedge core_clk_i);
    zero <= 1'b0;
    $display("test prbs done");
  endtask : t_prbs
  task automatic wait_rx(input int n);
    repeat (n) @(posedge rx_clk);
  endtask : wait_rx
  task automatic t_pins;
    wr(bt_pkg::A_CTRL, 32'h0);
    wr(bt_pkg::A_IEN, 32'h1 << bt_pkg::S_LOSS);
    repeat (2) @(posedge core_clk_i);
    check("irq on", {30'h0, int_n, int_oe}, 32'h1);
    wr(bt_pkg::A_IEN, 32'h1 << bt_pkg::S_SYNC);
    repeat (2) @(posedge core_clk_i);
    check("irq mask", {31'h0, int_oe}, 32'h0);
    wr(bt_pkg::A_IEN, 32'h1 << bt_pkg::S_LOSS);
    test <= 1'b1;
    repeat (8) @(posedge core_clk_i);
    check("test oe", {29'h0, tx_oe, loss_oe, int_oe}, 32'h0);
    test <= 1'b0;
    repeat (8) @(posedge core_clk_i);
    check("oe back", {29'h0, tx_oe, loss_oe, int_oe}, 32'h7);
    $display("test pins done");
  endtask : t_pins
  initial begin
    rstn_i = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hwdata = 32'h0;
    {tl, lc, test, flip, zero} = 5'h00;
    n_errors = 0;
    compares = 0;
    repeat (12) @(posedge core_clk_i);
    rstn_i <= 1'b1;
    repeat (4) @(posedge core_clk_i);
    t_regs();
    t_tx();
    t_prbs();
    t_pins();
    complete_run();
  end
  initial begin
    #2_000_000;
    hang("run");
  end
endmodule : tb_top
`default_nettype wire
